// [dv/host_link_model.sv]
// Far-side model: frame sender and measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
   input  wire logic       clk_i,       // System clock
   input  wire logic       rst_i,       // Async reset
   input  wire logic       send_i,      // Send one valid frame
   input  wire logic       seq_start_i, // Sequence start pulse
   input  wire logic [7:0] seq_len_i,   // Sequence length, cycles
   output logic            frame_o,     // Valid frame pulse
   output logic            done_o       // Sequence done pulse
);
   logic [7:0] left_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) frame_o <= 1'b0;
      else frame_o <= send_i;
   end
   // Short length answers promptly, long one outlasts the interval
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         left_q <= 8'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= (left_q == 8'h01);
         if (seq_start_i) left_q <= seq_len_i;
         else if (left_q != 8'h00) left_q <= left_q - 8'h01;
      end
   end
endmodule
`default_nettype wire

// [dv/link_idle_fault_flag_automonitor_timers_bench.sv]
// Self-checking bench of the inactivity and periodic-measure timers
`timescale 1ns/100ps
`default_nettype none
`include "idle_timer_defs.svh"
module link_idle_fault_flag_automonitor_timers_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [9:0]  adr = 10'h000;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0]  be = 4'hF;
   logic        send = 1'b0;
   logic [7:0]  slen = 8'h03;
   logic [31:0] rdata;
   logic        waitreq;
   logic        start;
   logic [15:0] cmask;
   logic [7:0]  amask;
   logic        tsel;
   logic        fault;
   logic        pd;
   logic        irq;
   logic        frame;
   logic        done;
   logic [31:0] v;
   int          fails = 0;
   int          cmp_count = 0;
   int          n;
   always #20 clk_i = ~clk_i;
   idle_timer #(.TICK_DIV(4)) idle_timer_inst (
      .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .frame_valid_i(frame),
      .seq_done_i(done), .seq_start_o(start), .cell_mask_o(cmask),
      .aux_mask_o(amask), .temp_sel_o(tsel), .idle_fault_o(fault),
      .powerdown_o(pd), .irq_o(irq));
   host_link_model host_link_model_inst (
      .clk_i(clk_i), .rst_i(rst_i), .send_i(send), .seq_start_i(start),
      .seq_len_i(slen), .frame_o(frame), .done_o(done));
   task wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task range(input string nm, input int lo, input int hi,
              input logic [31:0] s);
      cmp_count++;
      if ((s >= lo && s <= hi) !== 1'b1) begin
         fails++;
         $display("BAD %s exp %0d..%0d seen %0d", nm, lo, hi, s);
      end
   endtask
   task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      adr <= {idx, 2'b00};
      wd <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      v = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n == 50) fails++;
   endtask
   task frm;
      @(posedge clk_i);
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
   endtask
   task wstart;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (start !== 1'b1 && n < 200);
   endtask
   task cnt_starts(input int k);
      n = 0;
      repeat (k) begin
         @(negedge clk_i);
         if (start === 1'b1) n++;
      end
   endtask
   task t_reset;
      check("pd", 32'h0, pd);
      check("fault", 32'h0, fault);
      bus(1'b0, `REG_PERIODS_IDX, 32'h0);
      check("periods", 32'h0, v);
      bus(1'b0, `REG_PERIODIC_MEASURE_PERIOD_IDX, 32'h0);
      check("periodic_measure_period", 32'h0, v);
      bus(1'b1, 8'h10, 32'hFFFF_FFFF);
      bus(1'b0, 8'h10, 32'h0);
      check("unmapped", 32'h0, v);
      be <= 4'hE;
      bus(1'b1, `REG_PERIODS_IDX, 32'hFF);
      be <= 4'hF;
      bus(1'b0, `REG_PERIODS_IDX, 32'h0);
      check("be_ignored", 32'h0, v);
      $display("test reset done");
   endtask
   task t_count;
      bus(1'b1, `REG_CTRL_IDX, 32'h1);
      bus(1'b1, `REG_COUNTER_IDX, 32'h100);
      frm;
      bus(1'b0, `REG_COUNTER_IDX, 32'h0);
      range("count_keep", 256, 260, v);
      bus(1'b1, `REG_CTRL_IDX, 32'h0);
      frm;
      bus(1'b0, `REG_COUNTER_IDX, 32'h0);
      range("count_clear", 0, 2, v);
      $display("test counter done");
   endtask
   task t_fault;
      bus(1'b1, `REG_PERIODS_IDX, 32'h21);
      bus(1'b1, `REG_IRQ_MASK_IDX, 32'h1);
      bus(1'b1, `REG_COUNTER_IDX, 32'h18E);
      @(negedge clk_i);
      check("fault_early", 32'h0, fault);
      n = 0;
      while (fault !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      range("fault_delay", 3, 20, n);
      repeat (2) @(negedge clk_i);
      check("irq_set", 32'h1, irq);
      bus(1'b0, `REG_STATUS_IDX, 32'h0);
      check("st_fault", 32'h1, v & 32'h1);
      bus(1'b1, `REG_STATUS_IDX, 32'h1);
      repeat (2) @(negedge clk_i);
      check("irq_clr", 32'h0, irq);
      frm;
      repeat (3) @(negedge clk_i);
      check("fault_gone", 32'h0, fault);
      $display("test fault done");
   endtask
   task t_off;
      bus(1'b1, `REG_PERIODS_IDX, 32'hEF);
      bus(1'b1, `REG_COUNTER_IDX, 32'hFF_FFF0);
      repeat (100) @(posedge clk_i);
      bus(1'b0, `REG_COUNTER_IDX, 32'h0);
      check("count_sat", 32'hFF_FFFF, v);
      check("fault_rsvd", 32'h0, fault);
      check("pd_rsvd", 32'h0, pd);
      bus(1'b1, `REG_PERIODS_IDX, 32'h0);
      repeat (3) @(negedge clk_i);
      check("fault_off", 32'h0, fault);
      check("pd_off", 32'h0, pd);
      frm;
      $display("test disabled codes done");
   endtask
   task t_pd;
      bus(1'b1, `REG_PERIODS_IDX, 32'h21);
      bus(1'b1, `REG_COUNTER_IDX, 32'h7CB);
      @(negedge clk_i);
      check("pd_early", 32'h0, pd);
      n = 0;
      while (pd !== 1'b1 && n < 60) begin
         @(negedge clk_i);
         n++;
      end
      range("pd_delay", 12, 40, n);
      frm;
      repeat (3) @(negedge clk_i);
      check("pd_latched", 32'h1, pd);
      $display("test power-down done");
   endtask
   task t_mon(input logic [3:0] code, input int per);
      bus(1'b1, `REG_PERIODIC_MEASURE_PERIOD_IDX, {28'h0, code});
      wstart;
      range("start_prompt", 1, 8, n);
      @(negedge clk_i);
      check("masks", 32'h1_FFFF_FF, {cmask, amask, tsel});
      wstart;
      wstart;
      check("interval", per, n);
   endtask
   task t_periodic;
      bus(1'b1, `REG_CHAN_SEL_IDX, 32'hFFFF_FFFF);
      bus(1'b0, `REG_CHAN_SEL_IDX, 32'h0);
      check("chan_sel", 32'hFFFF_FF80, v);
      bus(1'b1, `REG_PERIODIC_MEASURE_PERIOD_IDX, 32'hF1);
      bus(1'b0, `REG_PERIODIC_MEASURE_PERIOD_IDX, 32'h0);
      check("am_rsvd", 32'h1, v);
      t_mon(4'h1, 16);
      t_mon(4'h2, 32);
      t_mon(4'h3, 80);
      slen <= 8'h3C;
      bus(1'b1, `REG_PERIODIC_MEASURE_PERIOD_IDX, 32'h1);
      wstart;
      while (done !== 1'b1) @(negedge clk_i);
      wstart;
      range("back_to_back", 1, 3, n);
      bus(1'b1, `REG_CHAN_SEL_IDX, 32'h0);
      cnt_starts(150);
      check("no_chan", 32'h0, n);
      bus(1'b1, `REG_PERIODIC_MEASURE_PERIOD_IDX, 32'h0);
      bus(1'b1, `REG_CHAN_SEL_IDX, 32'hFFFF_FF80);
      cnt_starts(150);
      check("mon_off", 32'h0, n);
      $display("test periodic done");
   endtask
   initial begin
      #(40 * 20000);
      fails++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_count;
      t_fault;
      t_off;
      t_pd;
      t_periodic;
      wrap_up;
   end
endmodule
`default_nettype wire

// [verilog/idle_timer.sv]
// Link inactivity counter with fault and power-down limits, periodic measure
//
// Overview of operation
// - Idle time beyond power-down code forces shutdown; 0 and 14-15 disable.
// - Idle time beyond fault code sets link idle fault; same code table.
// - One 24-bit up-counter on 4 kHz tick feeds both limit compares.
// - Writing the counter register loads that value as current count.
// - Reading the counter returns the live count.
// - Periodic measure starts each selected interval; code 0 switches off.
// - Interval shorter than sequence: next sequence starts back to back.
// - Writing interval field restarts interval timer and starts monitoring.
// - Upper four interval register bits ignore writes and read zero.
// - Measure only masked channels, and only while interval is non-zero.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "idle_timer_defs.svh"
module idle_timer #(
   parameter int TICK_DIV = `TICK_DIV_CYCLES
) (
   input  wire logic        clk_i,              // System clock, 25 MHz
   input  wire logic        rst_i,              // Async reset, active high
   input  wire logic [9:0]  avs_address_i,      // Avalon byte address
   input  wire logic        avs_read_i,         // Avalon read
   input  wire logic        avs_write_i,        // Avalon write
   input  wire logic [31:0] avs_writedata_i,    // Avalon write data
   input  wire logic [3:0]  avs_byteenable_i,   // Avalon byte enables
   output logic      [31:0] avs_readdata_o,     // Avalon read data
   output logic             avs_waitrequest_o,  // Avalon wait request
   input  wire logic        frame_valid_i,      // Valid frame received pulse
   input  wire logic        seq_done_i,         // Measure sequence finished
   output logic             seq_start_o,        // Measure sequence start pulse
   output logic      [15:0] cell_mask_o,        // Cells to measure
   output logic      [7:0]  aux_mask_o,         // Aux inputs to measure
   output logic             temp_sel_o,         // Measure die temperature
   output logic             idle_fault_o,       // Link idle fault level
   output logic             powerdown_o,        // Shutdown request, latched
   output logic             irq_o               // Interrupt, active high
);
   if (TICK_DIV < 2) begin
      $error("idle_timer: TICK_DIV must be at least 2");
   end

   tick_if tk ();
   tick_gen #(.DIV(TICK_DIV)) u_tick (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .tk    (tk.src)
   );

   // Code to limit in 4 kHz ticks; reserved codes give zero (disabled)
   function automatic idle_timer_pkg::count_t idle_limit(input logic [3:0] c);
      logic [31:0] ms;
      ms = 32'h0;
      case (c)
         4'h1:    ms = 32'h64;
         4'h2:    ms = 32'h1F4;
         4'h3:    ms = 32'h3E8;
         4'h4:    ms = 32'h7D0;
         4'h5:    ms = 32'h1388;
         4'h6:    ms = 32'h2710;
         4'h7:    ms = 32'h7530;
         4'h8:    ms = 32'hEA60;
         4'h9:    ms = 32'h1D4C0;
         4'hA:    ms = 32'h493E0;
         4'hB:    ms = 32'h927C0;
         4'hC:    ms = 32'h1B7740;
         4'hD:    ms = 32'h36EE80;
         default: ms = 32'h0;
      endcase
      return 24'(ms * `TICKS_PER_MS);
   endfunction

   function automatic idle_timer_pkg::count_t am_limit(input logic [3:0] c);
      logic [31:0] ms;
      ms = 32'h0;
      case (c)
         4'h1:    ms = 32'h1;
         4'h2:    ms = 32'h2;
         4'h3:    ms = 32'h5;
         4'h4:    ms = 32'hA;
         4'h5:    ms = 32'h32;
         4'h6:    ms = 32'h64;
         4'h7:    ms = 32'hC8;
         4'h8:    ms = 32'h1F4;
         4'h9:    ms = 32'h3E8;
         4'hA:    ms = 32'h7D0;
         4'hB:    ms = 32'h1388;
         4'hC:    ms = 32'h2710;
         4'hD:    ms = 32'hEA60;
         4'hE:    ms = 32'h1B7740;
         4'hF:    ms = 32'h36EE80;
         default: ms = 32'h0;
      endcase
      return 24'(ms * `TICKS_PER_MS);
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Avalon slave: one wait cycle, registers change at the accepting edge
   logic       wait_q;
   logic [7:0] idx;
   logic       req;
   logic       wr_acc;
   logic       wr_periods;
   logic       wr_counter;
   logic       wr_periodic_measure_period;
   logic       wr_chan;
   logic       wr_status;
   logic       wr_mask;
   logic       wr_ctrl;

   assign idx        = avs_address_i[9:2];
   assign req        = avs_read_i | avs_write_i;
   assign wr_acc     = avs_write_i & ~wait_q;
   assign wr_periods = wr_acc & (idx == `REG_PERIODS_IDX);
   assign wr_counter = wr_acc & (idx == `REG_COUNTER_IDX);
   assign wr_periodic_measure_period  = wr_acc & (idx == `REG_PERIODIC_MEASURE_PERIOD_IDX) & avs_byteenable_i[0];
   assign wr_chan    = wr_acc & (idx == `REG_CHAN_SEL_IDX);
   assign wr_status  = wr_acc & (idx == `REG_STATUS_IDX) & avs_byteenable_i[0];
   assign wr_mask    = wr_acc & (idx == `REG_IRQ_MASK_IDX)
                       & avs_byteenable_i[0];
   assign wr_ctrl    = wr_acc & (idx == `REG_CTRL_IDX) & avs_byteenable_i[0];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req & wait_q);
      end
   end

   // Configuration registers
   logic [7:0]  periods_q;
   logic [3:0]  periodic_measure_period_q;
   logic [31:0] chan_q;
   logic        clr_dis_q;
   logic [`ST_W-1:0] irq_mask_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         periods_q <= `PERIODS_RST;
      end else if (wr_periods & avs_byteenable_i[0]) begin
         periods_q <= avs_writedata_i[7:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         periodic_measure_period_q <= `PERIODIC_MEASURE_PERIOD_RST;
      end else if (wr_periodic_measure_period) begin
         periodic_measure_period_q <= avs_writedata_i[`PERIODIC_MEASURE_PERIOD_HI:`PERIODIC_MEASURE_PERIOD_LO];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         chan_q <= `CHAN_SEL_RST;
      end else if (wr_chan) begin
         chan_q <= be_merge(chan_q, avs_writedata_i, avs_byteenable_i)
                   & `CHAN_SEL_USED;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clr_dis_q  <= 1'b0;
         irq_mask_q <= '0;
      end else begin
         if (wr_ctrl) begin
            clr_dis_q <= avs_writedata_i[`CTRL_CLR_DIS_BIT];
         end
         if (wr_mask) begin
            irq_mask_q <= avs_writedata_i[`ST_W-1:0];
         end
      end
   end

   // Inactivity counter: write beats frame beats tick; saturates at top
   idle_timer_pkg::count_t count_q;
   idle_timer_pkg::count_t count_wr;
   logic [31:0]            count_merged;
   assign count_merged = be_merge({8'h00, count_q}, avs_writedata_i,
                                  avs_byteenable_i);
   assign count_wr     = count_merged[23:0];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= `COUNTER_RST;
      end else if (wr_counter) begin
         count_q <= count_wr;
      end else if (frame_valid_i & ~clr_dis_q) begin
         count_q <= `COUNTER_RST;
      end else if (tk.tick && count_q != `COUNT_MAX) begin
         count_q <= count_q + 24'h000001;
      end
   end

   // Limit compares share the one counter
   idle_timer_pkg::count_t pd_lim;
   idle_timer_pkg::count_t flt_lim;
   logic pd_hit;
   logic flt_hit;
   assign pd_lim  = idle_limit(periods_q[`PD_PER_HI:`PD_PER_LO]);
   assign flt_lim = idle_limit(periods_q[`FLT_PER_HI:`FLT_PER_LO]);
   assign pd_hit  = (pd_lim != '0) && (count_q >= pd_lim);
   assign flt_hit = (flt_lim != '0) && (count_q >= flt_lim);

   logic flt_hit_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flt_hit_q    <= 1'b0;
         idle_fault_o <= 1'b0;
         powerdown_o  <= 1'b0;
      end else begin
         flt_hit_q    <= flt_hit;
         idle_fault_o <= flt_hit;
         if (pd_hit) begin
            powerdown_o <= 1'b1;
         end
      end
   end

   // Periodic measure: interval timer and back-to-back sequencer
   idle_timer_pkg::count_t     am_cnt_q;
   idle_timer_pkg::count_t     am_lim;
   idle_timer_pkg::seq_state_t seq_q;
   logic am_due;
   logic pend_q;
   logic any_chan;
   logic launch;
   assign am_lim   = am_limit(periodic_measure_period_q);
   assign am_due   = tk.tick && (am_lim != '0)
                     && (am_cnt_q >= am_lim - 24'h000001);
   assign any_chan = |chan_q;
   assign launch   = pend_q && (seq_q == idle_timer_pkg::SEQ_IDLE)
                     && (periodic_measure_period_q != 4'h0) && any_chan;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         am_cnt_q <= '0;
      end else if (wr_periodic_measure_period || periodic_measure_period_q == 4'h0 || am_due) begin
         am_cnt_q <= '0;
      end else if (tk.tick) begin
         am_cnt_q <= am_cnt_q + 24'h000001;
      end
   end

   // A due interval while busy stays pending, so the next run follows at once
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
      end else if (wr_periodic_measure_period) begin
         pend_q <= (avs_writedata_i[`PERIODIC_MEASURE_PERIOD_HI:`PERIODIC_MEASURE_PERIOD_LO] != '0);
      end else if (periodic_measure_period_q == 4'h0) begin
         pend_q <= 1'b0;
      end else if (am_due) begin
         pend_q <= 1'b1;
      end else if (launch) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         seq_q       <= idle_timer_pkg::SEQ_IDLE;
         seq_start_o <= 1'b0;
      end else begin
         seq_start_o <= launch;
         case (seq_q)
            idle_timer_pkg::SEQ_IDLE: begin
               if (launch) begin
                  seq_q <= idle_timer_pkg::SEQ_RUN;
               end
            end
            idle_timer_pkg::SEQ_RUN: begin
               if (seq_done_i) begin
                  seq_q <= idle_timer_pkg::SEQ_IDLE;
               end
            end
            default: seq_q <= idle_timer_pkg::SEQ_IDLE;
         endcase
      end
   end

   // Channel masks are captured at each launch and held for the run
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cell_mask_o <= '0;
         aux_mask_o  <= '0;
         temp_sel_o  <= 1'b0;
      end else if (launch) begin
         cell_mask_o <= chan_q[`CELL_SEL_HI:`CELL_SEL_LO];
         aux_mask_o  <= chan_q[`AUX_SEL_HI:`AUX_SEL_LO];
         temp_sel_o  <= chan_q[`TEMP_SEL_BIT];
      end
   end

   // Sticky events, write one to clear; a new event beats the clear
   logic [`ST_W-1:0] status_q;
   logic [`ST_W-1:0] ev;
   assign ev[`ST_FAULT_BIT] = flt_hit & ~flt_hit_q;
   assign ev[`ST_PD_BIT]    = pd_hit & ~powerdown_o;
   assign ev[`ST_AM_BIT]    = launch;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_q <= '0;
         irq_o    <= 1'b0;
      end else begin
         status_q <= ev | (status_q
                    & ~({`ST_W{wr_status}} & avs_writedata_i[`ST_W-1:0]));
         irq_o    <= |(status_q & irq_mask_q);
      end
   end

   // Read data is latched at the first request edge and stands in the
   // cycle where wait request is low; unmapped reads return zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i & wait_q) begin
         case (idx)
            `REG_PERIODS_IDX:  avs_readdata_o <= {24'h000000, periods_q};
            `REG_COUNTER_IDX:  avs_readdata_o <= {8'h00, count_q};
            `REG_PERIODIC_MEASURE_PERIOD_IDX:   avs_readdata_o <= {28'h0, periodic_measure_period_q};
            `REG_CHAN_SEL_IDX: avs_readdata_o <= chan_q;
            `REG_STATUS_IDX:   avs_readdata_o <= {29'h00000000, status_q};
            `REG_IRQ_MASK_IDX: avs_readdata_o <= {29'h00000000, irq_mask_q};
            `REG_CTRL_IDX:     avs_readdata_o <= {31'h00000000, clr_dis_q};
            default:           avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_waitrequest_o = wait_q;

   // Checks
   property p_pd_latch;
      @(posedge clk_i) disable iff (rst_i)
      pd_hit |=> powerdown_o [*4];
   endproperty
   a_pd_latch: assert property (p_pd_latch)
      else $error("power-down not held after limit reached");

   property p_fault_follows;
      @(posedge clk_i) disable iff (rst_i)
      (flt_lim != '0 && count_q >= flt_lim) |=> idle_fault_o;
   endproperty
   a_fault_follows: assert property (p_fault_follows)
      else $error("idle fault not raised at limit");

   property p_count_inc;
      @(posedge clk_i) disable iff (rst_i)
      (tk.tick && !wr_counter && !(frame_valid_i && !clr_dis_q)
       && count_q != `COUNT_MAX) |=> count_q == $past(count_q) + 24'h000001;
   endproperty
   a_count_inc: assert property (p_count_inc)
      else $error("counter did not advance on tick");

   property p_count_load;
      @(posedge clk_i) disable iff (rst_i)
      (wr_counter && avs_byteenable_i == 4'hF)
      |=> count_q == $past(avs_writedata_i[23:0]);
   endproperty
   a_count_load: assert property (p_count_load)
      else $error("counter write not loaded");

   property p_count_read;
      @(posedge clk_i) disable iff (rst_i)
      (avs_read_i && wait_q && idx == `REG_COUNTER_IDX)
      |=> avs_readdata_o[23:0] == $past(count_q) && !avs_waitrequest_o;
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("counter read value wrong");

   property p_frame_clear;
      @(posedge clk_i) disable iff (rst_i)
      (frame_valid_i && !clr_dis_q && !wr_counter) |=> count_q == '0;
   endproperty
   a_frame_clear: assert property (p_frame_clear)
      else $error("frame did not clear counter");

   property p_off_no_start;
      @(posedge clk_i) disable iff (rst_i)
      (periodic_measure_period_q == 4'h0 && !wr_periodic_measure_period) [*2] |=> !seq_start_o;
   endproperty
   a_off_no_start: assert property (p_off_no_start)
      else $error("measure started while switched off");

   property p_back_to_back;
      @(posedge clk_i) disable iff (rst_i)
      (seq_q == idle_timer_pkg::SEQ_RUN && seq_done_i && pend_q
       && periodic_measure_period_q != 4'h0 && any_chan && !wr_periodic_measure_period && !wr_chan)
      |=> ##1 seq_start_o;
   endproperty
   a_back_to_back: assert property (p_back_to_back)
      else $error("pending sequence not started back to back");

   property p_restart;
      @(posedge clk_i) disable iff (rst_i)
      wr_periodic_measure_period |=> am_cnt_q == '0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("interval write did not restart timer");

   property p_rsvd_zero;
      @(posedge clk_i) disable iff (rst_i)
      (avs_read_i && wait_q && idx == `REG_PERIODIC_MEASURE_PERIOD_IDX)
      |=> avs_readdata_o[7:4] == 4'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved interval bits read non-zero");

   c_powerdown: cover property (@(posedge clk_i) disable iff (rst_i)
      $rose(powerdown_o));
   c_fault: cover property (@(posedge clk_i) disable iff (rst_i)
      $rose(idle_fault_o));
   c_b2b: cover property (@(posedge clk_i) disable iff (rst_i)
      seq_done_i && pend_q ##2 seq_start_o);
   c_irq: cover property (@(posedge clk_i) disable iff (rst_i)
      $rose(irq_o));
endmodule
`default_nettype wire

// [verilog/idle_timer_defs.svh]
// Register indices, field positions, reset values and timing counts
`ifndef IDLE_TIMER_DEFS_SVH
`define IDLE_TIMER_DEFS_SVH

// Register indices; byte address is four times the index
`define REG_PERIODS_IDX    8'h28
`define REG_COUNTER_IDX    8'h29
`define REG_PERIODIC_MEASURE_PERIOD_IDX     8'h32
`define REG_CHAN_SEL_IDX   8'h33
`define REG_STATUS_IDX     8'h40
`define REG_IRQ_MASK_IDX   8'h41
`define REG_CTRL_IDX       8'h42

// Field positions
`define PD_PER_HI          7
`define PD_PER_LO          4
`define FLT_PER_HI         3
`define FLT_PER_LO         0
`define PERIODIC_MEASURE_PERIOD_HI          3
`define PERIODIC_MEASURE_PERIOD_LO          0
`define CTRL_CLR_DIS_BIT   0
`define ST_FAULT_BIT       0
`define ST_PD_BIT          1
`define ST_AM_BIT          2
`define ST_W               3
`define CELL_SEL_HI        31
`define CELL_SEL_LO        16
`define AUX_SEL_HI         15
`define AUX_SEL_LO         8
`define TEMP_SEL_BIT       7
`define CHAN_SEL_USED      32'hFFFF_FF80

// Reset values
`define PERIODS_RST        8'h00
`define COUNTER_RST        24'h000000
`define PERIODIC_MEASURE_PERIOD_RST         4'h0
`define CHAN_SEL_RST       32'h0000_0000

// Timing: inactivity tick of 4 kHz, system clock of 25 MHz
`define CLK_PERIOD_NS      40
`define TICK_PERIOD_US     250
`define TICK_DIV_CYCLES    ((`TICK_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define TICKS_PER_MS       (1000 / `TICK_PERIOD_US)
`define COUNT_MAX          24'hFFFFFF

`endif

// [verilog/idle_timer_pkg.sv]
// Types shared by the inactivity and periodic-measure timer block
package idle_timer_pkg;
   typedef enum logic {
      SEQ_IDLE,
      SEQ_RUN
   } seq_state_t;
   typedef logic [23:0] count_t;
endpackage

// [verilog/tick_gen.sv]
// Divider that makes the one-cycle 4 kHz time-base tick
`timescale 1ns/100ps
`default_nettype none
module tick_gen #(
   parameter int DIV = 6250
) (
   input  wire logic clk_i,   // System clock
   input  wire logic rst_i,   // Asynchronous reset, active high
   tick_if.src       tk       // Tick pulse out
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] div_q;
   logic          tick_q;

   if (DIV < 2) begin
      $error("tick_gen: DIV must be at least 2");
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == LAST) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + CW'(1);
         tick_q <= 1'b0;
      end
   end

   assign tk.tick = tick_q;
endmodule
`default_nettype wire

// [verilog/tick_if.sv]
// Carrier of the 4 kHz time-base tick between the divider and the timers
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface
`default_nettype wire
